/* rtl/clock_supervisor_pkg.sv */
// constants, types and helpers shared by the clock supervisor files
package clock_supervisor_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_OSC_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OSC_TUNING = 8'h04;
    localparam logic [7:0] OFS_FLAGS_TWO = 8'h08;
    localparam logic [7:0] OFS_ENABLES_TWO = 8'h0C;
    localparam logic [7:0] OFS_SUPERVISOR_STATUS = 8'h10;

    // oscillator_control fields
    localparam int SCS_BIT = 0;
    localparam int LTS_BIT = 1;
    localparam int HTS_BIT = 2;
    localparam int STARTUP_TIMEOUT_STATUS_BIT = 3;
    localparam int IFS_LSB = 4;
    localparam int IFS_MSB = 6;
    localparam logic [2:0] IFS_RESET = 3'h6;
    localparam logic SCS_RESET = 1'b0;

    // oscillator_tuning field
    localparam int TRIM_MSB = 4;
    localparam logic [4:0] TRIM_RESET = 5'h00;

    // flag, enable and supervisor status fields
    localparam int FAIL_FLAG_BIT = 0;
    localparam int FAIL_IE_BIT = 0;
    localparam int STAT_FAIL_SAFE_BIT = 0;
    localparam int STAT_OST_RUN_BIT = 1;
    localparam int STAT_CPU_RUN_BIT = 2;

    // start-up timer: external falling edges counted before stable
    localparam int OST_WIDTH = 11;
    localparam logic [OST_WIDTH-1:0] OST_LAST = 11'h3FF;
    localparam logic [OST_WIDTH-1:0] OST_ONE = 11'h001;

    // sample clock divider on the low-frequency internal oscillator
    localparam int LF_DIV_WIDTH = 6;
    localparam logic [LF_DIV_WIDTH-1:0] LF_HALF = 6'h1F;
    localparam logic [LF_DIV_WIDTH-1:0] LF_LAST = 6'h3F;
    localparam logic [LF_DIV_WIDTH-1:0] LF_ONE = 6'h01;

    // oscillator_mode_select encodings
    localparam logic [2:0] MODE_LOW_POWER_CRYSTAL = 3'h0;
    localparam logic [2:0] MODE_CRYSTAL = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;
    localparam logic [2:0] MODE_EXTERNAL_CLOCK_INPUT = 3'h3;
    localparam logic [2:0] MODE_INTERNAL_IO = 3'h4;
    localparam logic [2:0] MODE_INTERNAL_CLKOUT = 3'h5;
    localparam logic [2:0] MODE_RESISTOR_CAPACITOR_IO = 3'h6;
    localparam logic [2:0] MODE_RESISTOR_CAPACITOR = 3'h7;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum {
        ST_POWERUP,
        ST_INTERNAL,
        ST_OST,
        ST_WAIT_INT_FALL,
        ST_HOLD_LOW,
        ST_EXTERNAL,
        ST_ASLEEP
    } sup_state_t;

    typedef struct packed {
        logic switchover_enable_cfg;
        logic fail_monitor_enable;
        logic powerup_timer_enable;
        logic [2:0] oscillator_mode_select;
    } osc_cfg_t;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } edge_t;

    function automatic logic is_crystal(input logic [2:0] mode);
        is_crystal = (mode == MODE_LOW_POWER_CRYSTAL) || (mode == MODE_CRYSTAL)
            || (mode == MODE_HIGH_SPEED_CRYSTAL);
    endfunction : is_crystal

    function automatic logic is_external(input logic [2:0] mode);
        is_external = is_crystal(mode) || (mode == MODE_EXTERNAL_CLOCK_INPUT)
            || (mode == MODE_RESISTOR_CAPACITOR_IO) || (mode == MODE_RESISTOR_CAPACITOR);
    endfunction : is_external

endpackage : clock_supervisor_pkg

/* rtl/level_sync.sv */
// two-flop synchroniser with rise and fall pulses
`timescale 1ns/1ps
module level_sync (
    input wire logic core_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic async_in, // oscillator level from outside
    output clock_supervisor_pkg::edge_t sig // synced level and edge pulses
);
    import clock_supervisor_pkg::*;

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // meta_r feeds sync_r only
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign sig.level = sync_r;
    assign sig.rise = sync_r & ~prev_r;
    assign sig.fall = ~sync_r & prev_r;

endmodule : level_sync

/* rtl/two_speed_startup_fail_safe_monitor.sv */
// two-speed start-up sequencer and fail-safe clock monitor with ahb-lite registers
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module two_speed_startup_fail_safe_monitor (
    input wire logic core_clk, // system clock, 10 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response, always okay
    output logic [31:0] hrdata, // ahb read data
    input clock_supervisor_pkg::osc_cfg_t cfg, // configuration word bits
    input wire logic powerup_timer_done, // power-up timer expired
    input wire logic sleep_req, // sleep instruction pulse
    input wire logic wake_up, // wake-up from sleep pulse
    input wire logic ext_osc, // external oscillator level
    input wire logic int_osc, // internal oscillator level
    input wire logic lf_osc, // low-frequency internal oscillator level
    input wire logic high_osc_stable, // high-frequency internal osc stable
    input wire logic low_osc_stable, // low-frequency internal osc stable
    output logic sys_clk_ext, // system clock from external source
    output logic sys_clk_hold_low, // system clock held low for switch
    output logic cpu_run, // core may execute
    output logic ost_running, // start-up timer counting
    output logic [2:0] internal_frequency_select, // internal osc frequency
    output logic [4:0] frequency_trim, // internal osc trim
    output logic osc_fail_irq // fail interrupt request
);
    import clock_supervisor_pkg::*;

    edge_t ext_e;
    edge_t int_e;
    edge_t lf_e;

    sup_state_t state_r;
    sup_state_t state_nxt;
    sup_state_t launch;

    logic [OST_WIDTH-1:0] ost_cnt_r;
    logic [LF_DIV_WIDTH-1:0] lf_cnt_r;
    logic latch_r;
    logic fail_safe_r;
    logic startup_timeout_status_r;
    logic scs_r;
    logic [2:0] ifs_r;
    logic [4:0] trim_r;
    logic fail_flag_r;
    logic fail_ie_r;
    logic sys_clk_ext_r;
    logic hold_low_r;
    logic cpu_run_r;
    logic ost_running_r;

    logic addr_ph_r;
    logic wr_ph_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;

    logic bus_take;
    logic wr_ctrl;
    logic wr_tune;
    logic wr_flags;
    logic wr_enables;
    logic scs_new;
    logic scs_toggle;
    logic scs_eff;
    logic two_speed_en;
    logic samp_rise;
    logic samp_fall;
    logic mon_active;
    logic fail_det;
    logic [31:0] rd_mux;

    // oscillator levels arrive unrelated to core_clk
    level_sync u_ext_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(ext_osc),
        .sig(ext_e)
    );

    level_sync u_int_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(int_osc),
        .sig(int_e)
    );

    level_sync u_lf_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(lf_osc),
        .sig(lf_e)
    );

    // where a start-up goes, given the mode and the select bit
    function automatic sup_state_t launch_state(input logic [2:0] mode, input logic system_clock_select);
        if (system_clock_select)
            launch_state = ST_INTERNAL;
        else if (is_crystal(mode))
            launch_state = ST_OST;
        else if (is_external(mode))
            launch_state = ST_EXTERNAL;
        else
            launch_state = ST_INTERNAL;
    endfunction : launch_state

    // bus decode: zero wait states, so hreadyout stays high
    assign bus_take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_ctrl = wr_ph_r && (addr_r == OFS_OSC_CONTROL);
    assign wr_tune = wr_ph_r && (addr_r == OFS_OSC_TUNING);
    assign wr_flags = wr_ph_r && (addr_r == OFS_FLAGS_TWO);
    assign wr_enables = wr_ph_r && (addr_r == OFS_ENABLES_TWO);
    assign scs_new = hwdata[SCS_BIT];
    assign scs_toggle = wr_ctrl && (scs_new != scs_r);
    // select value in force from this edge on, so a restart by toggle runs the core at once unless it enters the timer without two-speed start-up
    assign scs_eff = scs_toggle ? scs_new : scs_r;

    assign two_speed_en = (cfg.switchover_enable_cfg || cfg.fail_monitor_enable)
        && is_crystal(cfg.oscillator_mode_select) && !scs_eff;

    // launch uses the select value being written when it toggles
    assign launch = launch_state(cfg.oscillator_mode_select, scs_eff);

    // sample clock is the divider msb; its edges fall on the half and wrap points
    assign samp_rise = lf_e.rise && (lf_cnt_r == LF_HALF);
    assign samp_fall = lf_e.rise && (lf_cnt_r == LF_LAST);

    // only in steady external operation, never during start-up
    assign mon_active = cfg.fail_monitor_enable && (state_r == ST_EXTERNAL)
        && !fail_safe_r;
    // an external fall in the closing cycle still counts as seen
    assign fail_det = mon_active && samp_fall && !latch_r && !ext_e.fall;

    always_comb
    begin
        state_nxt = state_r;
        if (sleep_req)
            state_nxt = ST_ASLEEP;
        else if (scs_toggle)
            state_nxt = launch;
        else if (fail_det)
            state_nxt = ST_INTERNAL;
        else
        begin
            unique case (state_r)
                ST_POWERUP:
                begin
                    if (!cfg.powerup_timer_enable || powerup_timer_done)
                        state_nxt = launch;
                end
                ST_INTERNAL:
                begin
                    state_nxt = ST_INTERNAL;
                end
                ST_OST:
                begin
                    if (ext_e.fall && (ost_cnt_r == OST_LAST))
                        state_nxt = ST_WAIT_INT_FALL;
                end
                ST_WAIT_INT_FALL:
                begin
                    if (int_e.fall)
                        state_nxt = ST_HOLD_LOW;
                end
                ST_HOLD_LOW:
                begin
                    if (ext_e.fall)
                        state_nxt = ST_EXTERNAL;
                end
                ST_EXTERNAL:
                begin
                    state_nxt = ST_EXTERNAL;
                end
                ST_ASLEEP:
                begin
                    if (wake_up)
                        state_nxt = launch;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_r <= ST_POWERUP;
        else
            state_r <= state_nxt;
    end

    // count restarts on every entry to the timer
    always_ff @(posedge core_clk)
    begin
        if (rst)
            ost_cnt_r <= '0;
        else if (state_nxt != ST_OST || state_r != ST_OST)
            ost_cnt_r <= '0;
        else if (ext_e.fall)
            ost_cnt_r <= ost_cnt_r + OST_ONE;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            lf_cnt_r <= '0;
        else if (lf_e.rise)
            lf_cnt_r <= lf_cnt_r + LF_ONE;
    end

    // set wins so a fall on the clearing edge is not lost
    always_ff @(posedge core_clk)
    begin
        if (rst)
            latch_r <= 1'b0;
        else if (ext_e.fall)
            latch_r <= 1'b1;
        else if (samp_rise)
            latch_r <= 1'b0;
    end

    // fail condition; a fresh failure beats a same-cycle clear
    always_ff @(posedge core_clk)
    begin
        if (rst)
            fail_safe_r <= 1'b0;
        else if (fail_det)
            fail_safe_r <= 1'b1;
        else if (sleep_req)
            fail_safe_r <= 1'b0;
        else if (scs_toggle && launch != ST_OST)
            fail_safe_r <= 1'b0;
        else if (state_nxt == ST_EXTERNAL && state_r != ST_EXTERNAL)
            fail_safe_r <= 1'b0;
    end

    // status follows the source: set from the internal-fall edge onward
    always_ff @(posedge core_clk)
    begin
        if (rst)
            startup_timeout_status_r <= 1'b0;
        else
            startup_timeout_status_r <= ((state_nxt == ST_HOLD_LOW) || (state_nxt == ST_EXTERNAL))
                && is_external(cfg.oscillator_mode_select);
    end

    // clock steering outputs, registered from the next state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sys_clk_ext_r <= 1'b0;
            hold_low_r <= 1'b0;
            cpu_run_r <= 1'b0;
            ost_running_r <= 1'b0;
        end
        else
        begin
            sys_clk_ext_r <= (state_nxt == ST_EXTERNAL);
            hold_low_r <= (state_nxt == ST_HOLD_LOW);
            ost_running_r <= (state_nxt == ST_OST);
            // without two-speed start-up the core waits out the timer
            cpu_run_r <= (state_nxt == ST_INTERNAL) || (state_nxt == ST_EXTERNAL)
                || (((state_nxt == ST_OST) || (state_nxt == ST_WAIT_INT_FALL))
                && two_speed_en);
        end
    end

    // software select bit; automatic switches never write it
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            scs_r <= SCS_RESET;
            ifs_r <= IFS_RESET;
        end
        else if (wr_ctrl)
        begin
            scs_r <= scs_new;
            ifs_r <= hwdata[IFS_MSB:IFS_LSB];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            trim_r <= TRIM_RESET;
        else if (wr_tune)
            trim_r <= hwdata[TRIM_MSB:0];
    end

    // a clear while the condition stands is ignored; set wins
    always_ff @(posedge core_clk)
    begin
        if (rst)
            fail_flag_r <= 1'b0;
        else if (fail_det)
            fail_flag_r <= 1'b1;
        else if (wr_flags && (hwdata[FAIL_FLAG_BIT] || !fail_safe_r))
            fail_flag_r <= hwdata[FAIL_FLAG_BIT];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            fail_ie_r <= 1'b0;
        else if (wr_enables)
            fail_ie_r <= hwdata[FAIL_IE_BIT];
    end

    always_comb
    begin
        rd_mux = '0;
        unique case (haddr[7:0])
            OFS_OSC_CONTROL:
            begin
                rd_mux[SCS_BIT] = scs_r;
                rd_mux[LTS_BIT] = low_osc_stable;
                rd_mux[HTS_BIT] = high_osc_stable;
                rd_mux[STARTUP_TIMEOUT_STATUS_BIT] = startup_timeout_status_r;
                rd_mux[IFS_MSB:IFS_LSB] = ifs_r;
            end
            OFS_OSC_TUNING:
            begin
                rd_mux[TRIM_MSB:0] = trim_r;
            end
            OFS_FLAGS_TWO:
            begin
                rd_mux[FAIL_FLAG_BIT] = fail_flag_r;
            end
            OFS_ENABLES_TWO:
            begin
                rd_mux[FAIL_IE_BIT] = fail_ie_r;
            end
            OFS_SUPERVISOR_STATUS:
            begin
                rd_mux[STAT_FAIL_SAFE_BIT] = fail_safe_r;
                rd_mux[STAT_OST_RUN_BIT] = ost_running_r;
                rd_mux[STAT_CPU_RUN_BIT] = cpu_run_r;
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
        if (haddr[31:8] != '0)
            rd_mux = '0;
    end

    // read data is sampled at the address phase so it is stable all data phase
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            addr_ph_r <= 1'b0;
            wr_ph_r <= 1'b0;
            addr_r <= '0;
            hrdata_r <= '0;
        end
        else if (hready)
        begin
            addr_ph_r <= bus_take;
            wr_ph_r <= bus_take && hwrite;
            // upper address bits set mean unmapped: park on a dead offset
            addr_r <= (haddr[31:8] == '0) ? haddr[7:0] : 8'hFF;
            if (bus_take && !hwrite)
                hrdata_r <= rd_mux;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign sys_clk_ext = sys_clk_ext_r;
    assign sys_clk_hold_low = hold_low_r;
    assign cpu_run = cpu_run_r;
    assign ost_running = ost_running_r;
    assign internal_frequency_select = ifs_r;
    assign frequency_trim = trim_r;
    assign osc_fail_irq = fail_flag_r && fail_ie_r;

endmodule : two_speed_startup_fail_safe_monitor

/* tb/clock_supervisor_asserts.sv */
// port-level checks for the clock supervisor
`timescale 1ns/1ps
module clock_supervisor_asserts (
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input clock_supervisor_pkg::osc_cfg_t cfg, // config word
    input wire logic sleep_req, // sleep pulse
    input wire logic sys_clk_ext, // external source
    input wire logic sys_clk_hold_low, // clock held low
    input wire logic cpu_run, // core runs
    input wire logic ost_running, // timer counts
    input wire logic [2:0] internal_frequency_select, // int frequency
    input wire logic osc_fail_irq // fail irq
);
    import clock_supervisor_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_reset_clears: assert property (disable iff (1'b0) rst |=> !sys_clk_ext && !cpu_run
        && !ost_running && internal_frequency_select == 3'h6 && !osc_fail_irq)
        else $error("reset state wrong");
    a_hold_exclusive: assert property (sys_clk_hold_low |-> !sys_clk_ext && !cpu_run)
        else $error("hold low overlaps running");
    // the external fall comes every few cycles, so a long hold means a lost edge
    a_hold_to_ext: assert property ($rose(sys_clk_hold_low) |-> ##[1:16] sys_clk_ext)
        else $error("no switch after hold");
    a_ost_internal: assert property (ost_running |-> !sys_clk_ext && !sys_clk_hold_low)
        else $error("external used during start-up");
    a_two_speed_run: assert property (ost_running |->
        cpu_run == (cfg.switchover_enable_cfg || cfg.fail_monitor_enable))
        else $error("core run wrong during start-up");
    a_no_ost_other: assert property (!is_crystal(cfg.oscillator_mode_select) |-> !ost_running)
        else $error("timer in non-crystal mode");
    a_ext_source: assert property (sys_clk_ext |-> is_external(cfg.oscillator_mode_select))
        else $error("external source in internal mode");
    a_sleep_aborts: assert property (sleep_req |=> !ost_running && !sys_clk_ext)
        else $error("sleep did not stop clocks");

    c_switch_ext: cover property ($rose(sys_clk_ext));
    c_fail_irq: cover property ($rose(osc_fail_irq));
    c_hold: cover property ($rose(sys_clk_hold_low));
endmodule : clock_supervisor_asserts

bind two_speed_startup_fail_safe_monitor clock_supervisor_asserts clock_supervisor_asserts_i (
    .core_clk, .rst, .cfg, .sleep_req, .sys_clk_ext, .sys_clk_hold_low, .cpu_run,
    .ost_running, .internal_frequency_select, .osc_fail_irq
);

/* tb/crystal_model.sv */
// external crystal: swings only while powered, stands high when stopped
`timescale 1ns/1ps
module crystal_model #(
    parameter int HALF_NS = 300
) (
    input wire logic run, // oscillator swinging
    output logic osc_out // oscillator level
);
    initial
    begin
        osc_out = 1'b1;
        forever
        begin
            #(HALF_NS);
            // a dead crystal gives no falling edges at all
            osc_out = run ? ~osc_out : 1'b1;
        end
    end
endmodule : crystal_model

/* tb/tb_top.sv */
// self-checking bench for the clock supervisor
`timescale 1ns/1ps
module tb_top;
    import clock_supervisor_pkg::*;
    logic core_clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, internal_frequency_select, ifs;
    logic [4:0] frequency_trim;
    osc_cfg_t cfg = osc_cfg_t'({3'b111, MODE_CRYSTAL});
    logic powerup_timer_done = 1'b0, sleep_req = 1'b0, wake_up = 1'b0, int_osc, lf_osc;
    logic high_osc_stable = 1'b1, low_osc_stable = 1'b1, ext_osc, sys_clk_ext;
    logic sys_clk_hold_low, cpu_run, ost_running, osc_fail_irq;
    logic xtal_run = 1'b0, count_on = 1'b0;
    logic [7:0] seed = 8'h38;
    int num_errors, n_checks, nfall, cycles;

    assign hready = hreadyout;
    two_speed_startup_fail_safe_monitor two_speed_startup_fail_safe_monitor_i (
        .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .cfg, .powerup_timer_done, .sleep_req, .wake_up,
        .ext_osc, .int_osc, .lf_osc, .high_osc_stable, .low_osc_stable, .sys_clk_ext,
        .sys_clk_hold_low, .cpu_run, .ost_running, .internal_frequency_select,
        .frequency_trim, .osc_fail_irq
    );
    crystal_model crystal_model_i (
        .run(xtal_run),
        .osc_out(ext_osc)
    );

    // half periods picked so oscillator edges meet a core clock edge only every 1200 ns (int_osc) and 2400 ns (lf_osc)
    initial
    begin
        core_clk = 1'b0;
        forever
            #50 core_clk = ~core_clk;
    end
    initial
    begin
        int_osc = 1'b0;
        forever
            #240 int_osc = ~int_osc;
    end
    initial
    begin
        lf_osc = 1'b0;
        forever
            #480 lf_osc = ~lf_osc;
    end

    always @(negedge ext_osc)
        if (count_on)
            nfall++;

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            $display("unexpected at %0t: run took too long", $time);
            tally_and_finish();
        end
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do
            @(posedge core_clk);
        while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do
            @(posedge core_clk);
        while (hready !== 1'b1);
        rd = hrdata;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(a, 1'b1, d, unused);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus(a, 1'b0, 32'h00000000, got);
        chk(got, exp);
        chk({hreadyout, hresp}, 32'h00000002);
    endtask : rd

    task automatic wait_for(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim)
        begin
            @(posedge core_clk);
            k++;
        end
        chk(s, v);
    endtask : wait_for

    task automatic pulse(input logic is_sleep);
        @(posedge core_clk);
        if (is_sleep)
            sleep_req <= 1'b1;
        else
            wake_up <= 1'b1;
        @(posedge core_clk);
        sleep_req <= 1'b0;
        wake_up <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : pulse

    // config changes only while reset is held, as on a real part
    task automatic do_reset(input osc_cfg_t c);
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        cfg <= c;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
    endtask : do_reset

    initial
    begin
        do_reset(cfg);
        repeat (20) @(posedge core_clk);
        chk(ost_running, 1'b0);
        rd(OFS_OSC_CONTROL, 32'h00000066);
        rd(OFS_OSC_TUNING, 32'h00000000);
        wr(OFS_OSC_TUNING, 32'h0000001F);
        rd(OFS_OSC_TUNING, 32'h0000001F);
        chk(frequency_trim, 32'h0000001F);
        wr(8'h14, 32'hFFFFFFFF);
        rd(8'h14, 32'h00000000);
        powerup_timer_done <= 1'b1;
        wait_for(ost_running, 1'b1, 10);
        chk(cpu_run, 1'b1);
        xtal_run <= 1'b1;
        count_on <= 1'b1;
        wait_for(ost_running, 1'b0, 8000);
        chk(nfall, 1024);
        count_on <= 1'b0;
        wait_for(sys_clk_hold_low, 1'b1, 20);
        chk(cpu_run, 1'b0);
        wait_for(sys_clk_ext, 1'b1, 20);
        rd(OFS_OSC_CONTROL, 32'h0000006E);
        $display("test start-up done");
        seed = lfsr_next(seed);
        ifs = seed[2:0];
        wr(OFS_OSC_CONTROL, {25'h0, ifs, 4'h0});
        wr(OFS_ENABLES_TWO, 32'h00000001);
        xtal_run <= 1'b0;
        wait_for(osc_fail_irq, 1'b1, 1500);
        chk(sys_clk_ext, 1'b0);
        chk(internal_frequency_select, ifs);
        rd(OFS_OSC_CONTROL, {25'h0, ifs, 4'h6});
        rd(OFS_SUPERVISOR_STATUS, 32'h00000005);
        wr(OFS_FLAGS_TWO, 32'h00000000);
        rd(OFS_FLAGS_TWO, 32'h00000001);
        wr(OFS_ENABLES_TWO, 32'h00000000);
        chk(osc_fail_irq, 1'b0);
        repeat (300) @(posedge core_clk);
        chk(sys_clk_ext, 1'b0);
        xtal_run <= 1'b1;
        wr(OFS_OSC_CONTROL, {25'h0, ifs, 4'h1});
        wr(OFS_OSC_CONTROL, {25'h0, ifs, 4'h0});
        rd(OFS_SUPERVISOR_STATUS, 32'h00000006);
        wr(OFS_FLAGS_TWO, 32'h00000000);
        rd(OFS_FLAGS_TWO, 32'h00000000);
        wait_for(sys_clk_ext, 1'b1, 8000);
        $display("test fail-safe done");
        pulse(1'b1);
        chk(sys_clk_ext, 1'b0);
        xtal_run <= 1'b0;
        pulse(1'b0);
        wait_for(ost_running, 1'b1, 10);
        repeat (700) @(posedge core_clk);
        rd(OFS_SUPERVISOR_STATUS, 32'h00000006);
        pulse(1'b1);
        chk(ost_running, 1'b0);
        rd(OFS_OSC_CONTROL, {25'h0, ifs, 4'h6});
        $display("test sleep done");
        for (int m = 0; m < 8; m++)
        begin
            seed = lfsr_next(seed);
            do_reset(osc_cfg_t'({seed[1:0], 1'b0, 3'(m)}));
            repeat (10) @(posedge core_clk);
            chk(ost_running, m < 3);
            chk(sys_clk_ext, m == 3 || m > 5);
            if (m < 3)
                chk(cpu_run, seed[1] | seed[0]);
        end
        do_reset(osc_cfg_t'({3'b010, MODE_RESISTOR_CAPACITOR}));
        wait_for(sys_clk_ext, 1'b1, 10);
        wait_for(sys_clk_ext, 1'b0, 1500);
        $display("test modes done");
        tally_and_finish();
    end
endmodule : tb_top
